/* File: ario_regs.vh */
// Register map, field positions, reset values and timing for the alarm relay interface.
// Assumes a 32-bit AHB-Lite bus, byte addresses, one aligned word per register.
`ifndef ARIO_REGS_VH
`define ARIO_REGS_VH

// ==========================================================
// Register byte offsets
`define ARIO_OFS_CTRL      8'h00
`define ARIO_OFS_DATA      8'h04
`define ARIO_OFS_OUTMASK   8'h08
`define ARIO_OFS_ENMASK    8'h0c
`define ARIO_OFS_POLMASK   8'h10
`define ARIO_OFS_SEVMASK   8'h14
`define ARIO_OFS_ALSTATE   8'h18
`define ARIO_OFS_RLYSTATE  8'h1c
`define ARIO_OFS_EVENT     8'h20
`define ARIO_OFS_INTSTAT   8'h24
`define ARIO_OFS_INTMASK   8'h28
`define ARIO_OFS_COIL      8'h2c

// ==========================================================
// Control word codes
`define ARIO_CW_GRP0       4'h0
`define ARIO_CW_GRP1       4'h1
`define ARIO_CW_GRP2       4'h2
`define ARIO_CW_GRP3       4'h3
`define ARIO_CW_RELAY      4'h4
`define ARIO_CW_SET        4'h5
`define ARIO_CW_RESET      4'h6
`define ARIO_CW_IDLE       4'hf

// ==========================================================
// Field positions
`define ARIO_INT_MAJOR     0
`define ARIO_INT_MINOR     1
`define ARIO_EVT_MAJOR     8
`define ARIO_COIL_BUSY     16

// ==========================================================
// Reset values
`define ARIO_RST_CTRL      4'hf
`define ARIO_RST_MASK32    32'h0000_0000
`define ARIO_RST_MASK8     8'h00

// ==========================================================
// Timing
`define ARIO_CLK_MHZ       50
`define ARIO_COIL_PULSE_US 10000
`define ARIO_COIL_CYCLES   (`ARIO_COIL_PULSE_US * `ARIO_CLK_MHZ)

`endif

/* File: ario_alarm_relay_io.v */
// Alarm input sampling, latching relay drive and AHB-Lite register file.
// Assumes alarm and relay sense pins are asynchronous; relays are external latching parts.
//
// How it works
// R1: Relay output mask is eight bits, bit zero drives relay one.
// R2: Mask one sets the relay, mask zero resets it.
// R3: Three 32-bit alarm masks, bit zero is alarm input one.
// R4: Enable mask selects monitored inputs; only their changes are reported.
// R5: Polarity one means active high, zero means active low.
// R6: Severity one marks a major alarm, zero a minor alarm.
// R7: Software loads output mask and the three alarm masks at start of service.
// R8: Isolated alarm line reads zero while its input is active.
// R9: Alarms are read eight at a time, group chosen by the control word.
// R10: Each relay has separate set and reset coil drive; state persists.
// R11: Relay contact state is read back when its group is selected.
// R12: Set pattern on data plus set-latch control word energizes set coils.
// R13: Software removes the coil command once the relay has latched.
// R14: Reset works as set, through the reset latch and reset coils.
// R15: Master reset low clears both latches and de-energizes every coil.
// R16: After reset software should read relays back and re-command them.
// R17: The 4-bit control word decodes one-hot to seven selects.
// R18: Changed enabled inputs raise an event with index and major/minor class.
`include "ario_regs.vh"

module ario_alarm_relay_io #(
  parameter       NUM_ALARMS  = 32,
  parameter       NUM_RELAYS  = 8,
  parameter [31:0] COIL_CYCLES = `ARIO_COIL_CYCLES
) (
  input  wire        mclk,
  input  wire        rst,
  input  wire        system_reset_low,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  input  wire [31:0] isolated_alarm_lines,
  input  wire [7:0]  relay_sense,
  output reg  [7:0]  set_coil,
  output reg  [7:0]  reset_coil,
  output reg         alarm_event,
  output reg  [4:0]  alarm_event_index,
  output reg         alarm_event_major,
  output wire        irq
);

  // ==========================================================
  // Coil pulse states
  localparam [1:0] ST_IDLE  = 2'b01;
  localparam [1:0] ST_PULSE = 2'b10;

  // ==========================================================
  // Functions
  function [6:0] cw_decode;
    input [3:0] cw;
    begin
      case (cw)
        `ARIO_CW_GRP0:  cw_decode = 7'h01;
        `ARIO_CW_GRP1:  cw_decode = 7'h02;
        `ARIO_CW_GRP2:  cw_decode = 7'h04;
        `ARIO_CW_GRP3:  cw_decode = 7'h08;
        `ARIO_CW_RELAY: cw_decode = 7'h10;
        `ARIO_CW_SET:   cw_decode = 7'h20;
        `ARIO_CW_RESET: cw_decode = 7'h40;
        default:        cw_decode = 7'h00;
      endcase
    end
  endfunction

  function [5:0] lowest_set;
    input [31:0] v;
    integer i;
    begin
      lowest_set = 6'h00;
      for (i = 31; i >= 0; i = i - 1) begin
        if (v[i]) begin
          lowest_set = {1'b1, i[4:0]};
        end
      end
    end
  endfunction

  // ==========================================================
  // Pin synchronisers
  reg  [31:0] al_s1_r, al_s2_r, al_s3_r, al_line_r;
  reg  [7:0]  rl_s1_r, rl_s2_r, rl_s3_r, rl_state_r;
  reg  [2:0]  mr_sync_r;
  reg         mr_active_r;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      al_s1_r     <= 32'hffff_ffff;
      al_s2_r     <= 32'hffff_ffff;
      al_s3_r     <= 32'hffff_ffff;
      al_line_r   <= 32'hffff_ffff;
      rl_s1_r     <= 8'h00;
      rl_s2_r     <= 8'h00;
      rl_s3_r     <= 8'h00;
      rl_state_r  <= 8'h00;
      mr_sync_r   <= 3'b000;
      mr_active_r <= 1'b1;
    end else begin
      al_s1_r   <= isolated_alarm_lines;
      al_s2_r   <= al_s1_r;
      al_s3_r   <= al_s2_r;
      al_line_r <= (al_s2_r & al_s3_r) | (al_line_r & (al_s2_r ^ al_s3_r)); // R8
      rl_s1_r   <= relay_sense;
      rl_s2_r   <= rl_s1_r;
      rl_s3_r   <= rl_s2_r;
      rl_state_r <= (rl_s2_r & rl_s3_r) | (rl_state_r & (rl_s2_r ^ rl_s3_r)); // R11
      mr_sync_r <= {mr_sync_r[1:0], system_reset_low};
      if (mr_sync_r[1] == mr_sync_r[2]) begin
        mr_active_r <= ~mr_sync_r[2];
      end
    end
  end

  // ==========================================================
  // AHB-Lite slave: writes zero wait, reads one wait state
  reg         wr_pend_r;
  reg         rd_wait_r;
  reg  [7:0]  addr_r;
  wire        accept;
  wire        wr_en;

  assign accept    = hsel & htrans[1] & hready;
  assign hreadyout = ~rd_wait_r;
  assign hresp     = 1'b0;
  assign wr_en     = wr_pend_r;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_pend_r <= 1'b0;
      rd_wait_r <= 1'b0;
      addr_r    <= 8'h00;
    end else begin
      wr_pend_r <= accept & hwrite;
      if (rd_wait_r) begin
        rd_wait_r <= 1'b0;
      end else begin
        rd_wait_r <= accept & ~hwrite;
      end
      if (accept) begin
        addr_r <= {haddr[7:2], 2'b00};
      end
    end
  end

  // ==========================================================
  // Software registers
  reg  [3:0]  ctrl_r;
  reg  [7:0]  data_r;
  reg  [7:0]  out_mask_r;
  reg  [31:0] en_mask_r, pol_mask_r, sev_mask_r;
  reg  [1:0]  int_stat_r, int_mask_r;
  reg  [1:0]  int_stat_nxt;
  wire [6:0]  sel;

  assign sel = cw_decode(ctrl_r); // R17
  assign irq = |(int_stat_r & int_mask_r);

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_r     <= `ARIO_RST_CTRL;
      data_r     <= `ARIO_RST_MASK8;
      out_mask_r <= `ARIO_RST_MASK8;
      en_mask_r  <= `ARIO_RST_MASK32;
      pol_mask_r <= `ARIO_RST_MASK32;
      sev_mask_r <= `ARIO_RST_MASK32;
      int_mask_r <= 2'b00;
    end else if (wr_en) begin
      case (addr_r)
        `ARIO_OFS_CTRL:    ctrl_r     <= hwdata[3:0];
        `ARIO_OFS_DATA:    data_r     <= hwdata[7:0];
        `ARIO_OFS_OUTMASK: out_mask_r <= hwdata[7:0]; // R1
        `ARIO_OFS_ENMASK:  en_mask_r  <= hwdata;      // R3
        `ARIO_OFS_POLMASK: pol_mask_r <= hwdata;
        `ARIO_OFS_SEVMASK: sev_mask_r <= hwdata;
        `ARIO_OFS_INTMASK: int_mask_r <= hwdata[1:0];
        default:           ctrl_r     <= ctrl_r;
      endcase
    end
  end

  // ==========================================================
  // Alarm change detection
  reg  [31:0] active_now;
  reg  [31:0] rep_r;
  reg  [31:0] changed;
  reg  [5:0]  pick;

  always @* begin
    active_now = ~(al_line_r ^ pol_mask_r);   // R5
    changed    = (active_now ^ rep_r) & en_mask_r; // R4
    pick       = lowest_set(changed);
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      rep_r             <= 32'h0000_0000;
      alarm_event       <= 1'b0;
      alarm_event_index <= 5'h00;
      alarm_event_major <= 1'b0;
    end else begin
      alarm_event <= pick[5];
      rep_r       <= (rep_r & en_mask_r) | (active_now & ~en_mask_r);
      if (pick[5]) begin
        rep_r[pick[4:0]]  <= active_now[pick[4:0]];  // R18
        alarm_event_index <= pick[4:0];
        alarm_event_major <= sev_mask_r[pick[4:0]];  // R6
      end
    end
  end

  // ==========================================================
  // Interrupt status, write one to clear, set wins
  always @* begin
    int_stat_nxt = int_stat_r;
    if (wr_en && addr_r == `ARIO_OFS_INTSTAT) begin
      int_stat_nxt = int_stat_r & ~hwdata[1:0];
    end
    if (alarm_event) begin
      int_stat_nxt[`ARIO_INT_MAJOR] = int_stat_nxt[`ARIO_INT_MAJOR] | alarm_event_major;
      int_stat_nxt[`ARIO_INT_MINOR] = int_stat_nxt[`ARIO_INT_MINOR] | ~alarm_event_major;
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      int_stat_r <= 2'b00;
    end else begin
      int_stat_r <= int_stat_nxt;
    end
  end

  // ==========================================================
  // Set and reset latches with timed output-mask pulse
  reg  [1:0]  state_r;
  reg  [31:0] pulse_cnt_r;
  wire        mask_wr;
  wire        sel_wr;
  wire [6:0]  wr_sel;
  wire [7:0]  wr_pat;

  assign mask_wr = wr_en && addr_r == `ARIO_OFS_OUTMASK;
  assign sel_wr  = wr_en && (addr_r == `ARIO_OFS_CTRL || addr_r == `ARIO_OFS_DATA);
  // A control-word write latches per the new word, so leaving set or reset never re-fires a coil
  assign wr_sel  = (addr_r == `ARIO_OFS_CTRL) ? cw_decode(hwdata[3:0]) : sel;
  assign wr_pat  = (addr_r == `ARIO_OFS_DATA) ? hwdata[7:0] : data_r;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r     <= ST_IDLE;
      pulse_cnt_r <= 32'h0000_0000;
      set_coil    <= 8'h00;
      reset_coil  <= 8'h00;
    end else if (mr_active_r) begin
      state_r     <= ST_IDLE;            // R15
      pulse_cnt_r <= 32'h0000_0000;
      set_coil    <= 8'h00;
      reset_coil  <= 8'h00;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (mask_wr) begin
            set_coil    <= hwdata[7:0];  // R2
            reset_coil  <= ~hwdata[7:0]; // R10
            pulse_cnt_r <= COIL_CYCLES;
            state_r     <= ST_PULSE;
          end else if (sel_wr) begin
            if (wr_sel[5]) begin
              set_coil <= wr_pat;   // R12
            end
            if (wr_sel[6]) begin
              reset_coil <= wr_pat; // R14
            end
          end
        end
        ST_PULSE: begin
          if (pulse_cnt_r <= 32'h0000_0001) begin
            set_coil   <= 8'h00;         // R13
            reset_coil <= 8'h00;
            state_r    <= ST_IDLE;
          end else begin
            pulse_cnt_r <= pulse_cnt_r - 32'h0000_0001;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Read mux, sampled in the read wait state
  reg  [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h0000_0000;
    case (addr_r)
      `ARIO_OFS_CTRL:     rd_mux[3:0] = ctrl_r;
      `ARIO_OFS_DATA: begin
        if (sel[0])      rd_mux[7:0] = al_line_r[7:0];   // R9
        else if (sel[1]) rd_mux[7:0] = al_line_r[15:8];
        else if (sel[2]) rd_mux[7:0] = al_line_r[23:16];
        else if (sel[3]) rd_mux[7:0] = al_line_r[31:24];
        else if (sel[4]) rd_mux[7:0] = rl_state_r;       // R11
        else             rd_mux[7:0] = data_r;
      end
      `ARIO_OFS_OUTMASK:  rd_mux[7:0] = out_mask_r;
      `ARIO_OFS_ENMASK:   rd_mux      = en_mask_r;
      `ARIO_OFS_POLMASK:  rd_mux      = pol_mask_r;
      `ARIO_OFS_SEVMASK:  rd_mux      = sev_mask_r;
      `ARIO_OFS_ALSTATE:  rd_mux      = rep_r;
      `ARIO_OFS_RLYSTATE: rd_mux[7:0] = rl_state_r;
      `ARIO_OFS_EVENT: begin
        rd_mux[4:0]            = alarm_event_index;
        rd_mux[`ARIO_EVT_MAJOR] = alarm_event_major;
      end
      `ARIO_OFS_INTSTAT:  rd_mux[1:0] = int_stat_r;
      `ARIO_OFS_INTMASK:  rd_mux[1:0] = int_mask_r;
      `ARIO_OFS_COIL: begin
        rd_mux[7:0]            = set_coil;
        rd_mux[15:8]           = reset_coil;
        rd_mux[`ARIO_COIL_BUSY] = state_r[1];
      end
      default:            rd_mux      = 32'h0000_0000;
    endcase
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_wait_r) begin
      hrdata <= rd_mux;
    end
  end

endmodule

/* File: ario_properties.sv */
// Port checker for the alarm relay interface.
// Assumes binding to ario_alarm_relay_io with one clock, mclk, and reset rst.
module ario_properties (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        system_reset_low,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic [7:0]  set_coil,
  input wire logic [7:0]  reset_coil,
  input wire logic        alarm_event,
  input wire logic [4:0]  alarm_event_index,
  input wire logic        alarm_event_major
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // ==========================================================
  // Bus answers
  a_resp_always_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_read_one_wait: assert property (hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_zero_wait: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout)
    else $error("write was stalled");
  a_wait_single_cycle: assert property (!hreadyout |=> hreadyout)
    else $error("wait state longer than one cycle");
  a_rdata_read_only: assert property (!$stable(hrdata) |-> !$past(hreadyout))
    else $error("read data changed outside a read");

  // ==========================================================
  // Coils and events
  a_coil_master_reset: assert property (!system_reset_low [*6] |-> set_coil == 8'h00 && reset_coil == 8'h00)
    else $error("coil energized during master reset");
  a_event_index_hold: assert property (!alarm_event |-> $stable(alarm_event_index))
    else $error("event index moved without event");
  a_event_class_hold: assert property (!alarm_event |-> $stable(alarm_event_major))
    else $error("event class moved without event");
endmodule

bind ario_alarm_relay_io ario_properties ario_properties_i (.mclk, .rst, .system_reset_low, .hsel, .htrans,
  .hwrite, .hready, .hreadyout, .hresp, .hrdata, .set_coil, .reset_coil, .alarm_event, .alarm_event_index,
  .alarm_event_major);

/* File: ario_relay_model.sv */
// Behavioural latching relays with one readback contact set each.
// Assumes a coil energized for one clock is enough to flip the contacts.
module ario_relay_model (
  input  wire logic       mclk,
  input  wire logic [7:0] set_coil,
  input  wire logic [7:0] reset_coil,
  output logic      [7:0] relay_sense
);
  timeunit 1ns;
  timeprecision 1ps;
  initial relay_sense = 8'h00;
  // Contacts hold without coil current; a set coil closes, a reset coil opens
  always @(posedge mclk) begin
    relay_sense <= (relay_sense | set_coil) & ~reset_coil;
  end
endmodule

/* File: ario_alarm_relay_io_tb.sv */
// Self-checking bench for the alarm relay interface over AHB-Lite.
// Assumes a short coil pulse parameter and the relay model on the coil pins.
`include "ario_regs.vh"
module ario_alarm_relay_io_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0, rst = 1'b1, system_reset_low = 1'b1, hsel = 1'b1, hwrite = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, lines = 32'hffff_ffff;
  wire         hreadyout, hresp, irq, alarm_event, alarm_event_major;
  wire  [31:0] hrdata;
  wire  [7:0]  relay_sense, set_coil, reset_coil;
  wire  [4:0]  alarm_event_index;
  int          err_count = 0, checks = 0;

  ario_alarm_relay_io #(.COIL_CYCLES(32'd20)) ario_alarm_relay_io_i (.mclk(mclk), .rst(rst),
    .system_reset_low(system_reset_low), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .isolated_alarm_lines(lines), .relay_sense(relay_sense), .set_coil(set_coil), .reset_coil(reset_coil),
    .alarm_event(alarm_event), .alarm_event_index(alarm_event_index), .alarm_event_major(alarm_event_major),
    .irq(irq));
  ario_relay_model ario_relay_model_i (.mclk(mclk), .set_coil(set_coil), .reset_coil(reset_coil),
    .relay_sense(relay_sense));

  initial forever #10 mclk = ~mclk;

  // ==========================================================
  // Bus and compare tasks
  task print_verdict;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wait_rdy;
    int n;
    n = 0;
    @(negedge mclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        err_count++;
        print_verdict;
      end
      @(negedge mclk);
    end
    @(posedge mclk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= 1'b1;
    htrans <= 2'b10;
    wait_rdy;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy;
  endtask
  task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    haddr <= {24'h0, a};
    hwrite <= 1'b0;
    htrans <= 2'b10;
    wait_rdy;
    htrans <= 2'b00;
    wait_rdy;
    chk(nm, e, hrdata);
  endtask
  task wait_evt;
    int n;
    n = 0;
    @(negedge mclk);
    while (alarm_event !== 1'b1) begin
      n++;
      if (n > 20) begin
        err_count++;
        print_verdict;
      end
      @(negedge mclk);
    end
    @(posedge mclk);
  endtask

  // ==========================================================
  // Test sequence
  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    rdc("ctrl reset", `ARIO_OFS_CTRL, 32'hf);
    rdc("enable reset", `ARIO_OFS_ENMASK, 32'h0);
    rdc("unmapped", 8'h40, 32'h0);
    $display("done: reset values");
    wr(`ARIO_OFS_OUTMASK, 32'h81);
    rdc("coil pulse", `ARIO_OFS_COIL, 32'h0001_7e81);
    repeat (30) @(posedge mclk);
    rdc("coil pulse end", `ARIO_OFS_COIL, 32'h0);
    rdc("relay state", `ARIO_OFS_RLYSTATE, 32'h81);
    wr(`ARIO_OFS_CTRL, `ARIO_CW_RELAY);
    rdc("relay on bus", `ARIO_OFS_DATA, 32'h81);
    $display("done: output mask");
    wr(`ARIO_OFS_CTRL, `ARIO_CW_SET);
    wr(`ARIO_OFS_DATA, 32'h0f);
    rdc("set latch", `ARIO_OFS_COIL, 32'h0f);
    wr(`ARIO_OFS_DATA, 32'h0);
    rdc("set released", `ARIO_OFS_COIL, 32'h0);
    wr(`ARIO_OFS_CTRL, `ARIO_CW_RESET);
    wr(`ARIO_OFS_DATA, 32'h0f);
    rdc("reset latch", `ARIO_OFS_COIL, 32'hf00);
    wr(`ARIO_OFS_DATA, 32'h0);
    wr(`ARIO_OFS_CTRL, `ARIO_CW_SET);
    wr(`ARIO_OFS_DATA, 32'h30);
    system_reset_low <= 1'b0;
    repeat (6) @(posedge mclk);
    chk("coils in reset", 32'h0, {16'h0, set_coil, reset_coil});
    system_reset_low <= 1'b1;
    repeat (6) @(posedge mclk);
    rdc("latch cleared", `ARIO_OFS_COIL, 32'h0);
    rdc("relay readback", `ARIO_OFS_RLYSTATE, 32'hb0);
    $display("done: latches");
    wr(`ARIO_OFS_POLMASK, 32'h80);
    wr(`ARIO_OFS_SEVMASK, 32'h4);
    wr(`ARIO_OFS_ENMASK, 32'h84);
    wr(`ARIO_OFS_INTMASK, 32'h3);
    lines <= 32'hffff_ffdb;
    wait_evt;
    chk("index", 32'd2, {27'h0, alarm_event_index});
    chk("major", 32'd1, {31'h0, alarm_event_major});
    rdc("major only", `ARIO_OFS_INTSTAT, 32'h1);
    chk("irq set", 32'd1, {31'h0, irq});
    wr(`ARIO_OFS_INTSTAT, 32'h1);
    rdc("cleared", `ARIO_OFS_INTSTAT, 32'h0);
    chk("irq clear", 32'd0, {31'h0, irq});
    wr(`ARIO_OFS_INTMASK, 32'h1);
    lines <= 32'hffff_ff5b;
    wait_evt;
    chk("index", 32'd7, {27'h0, alarm_event_index});
    chk("minor", 32'd0, {31'h0, alarm_event_major});
    rdc("minor stat", `ARIO_OFS_INTSTAT, 32'h2);
    chk("irq masked", 32'd0, {31'h0, irq});
    wr(`ARIO_OFS_INTMASK, 32'h3);
    @(posedge mclk);
    chk("irq unmasked", 32'd1, {31'h0, irq});
    rdc("alarm state", `ARIO_OFS_ALSTATE, 32'h24);
    for (int g = 0; g < 4; g++) begin
      wr(`ARIO_OFS_CTRL, g);
      rdc("group", `ARIO_OFS_DATA, (lines >> (8 * g)) & 32'hff);
    end
    rdc("no stale coil", `ARIO_OFS_COIL, 32'h0);
    wr(`ARIO_OFS_DATA, 32'h02);
    wr(`ARIO_OFS_CTRL, `ARIO_CW_SET);
    rdc("set by control word", `ARIO_OFS_COIL, 32'h02);
    wr(`ARIO_OFS_DATA, 32'h0);
    $display("done: alarms");
    print_verdict;
  end
endmodule
